// ### hdl/nand_host_pkg.sv
package nand_host_pkg;

    // NAND command codes.
    localparam logic [7:0] CMD_READ          = 8'h00;
    localparam logic [7:0] CMD_STATUS        = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH    = 8'h78;
    localparam logic [7:0] CMD_PARAM_PAGE    = 8'hEC;
    localparam logic [7:0] CMD_RESET         = 8'hFF;

    // Status byte field positions.
    localparam int ST_FAIL       = 0;
    localparam int ST_PRIOR_FAIL = 1;
    localparam int ST_ARRAY_IDLE = 5;
    localparam int ST_READY      = 6;
    localparam int ST_UNPROT     = 7;
    localparam logic [7:0] ST_DONT_CARE_MASK = 8'h1C;

    // Parameter page layout.
    localparam logic [9:0]  PP_TMODE_LO   = 10'h081;
    localparam logic [9:0]  PP_PROG_LO    = 10'h085;
    localparam logic [9:0]  PP_ERASE_LO   = 10'h087;
    localparam logic [9:0]  PP_READ_LO    = 10'h089;
    localparam logic [9:0]  PP_COLUMN_LO  = 10'h08B;
    localparam logic [9:0]  PP_CRC_END    = 10'h0FD;
    localparam logic [9:0]  PP_CRC_LO     = 10'h0FE;
    localparam logic [9:0]  PP_CRC_HI     = 10'h0FF;
    localparam logic [15:0] CRC_SEED      = 16'h4F4E;
    localparam logic [15:0] CRC_POLY      = 16'h8005;

    // Expected timing values in the parameter page.
    localparam logic [15:0] EXP_PROG      = 16'h0258;
    localparam logic [15:0] EXP_ERASE     = 16'h2710;
    localparam logic [15:0] EXP_READ      = 16'h0019;
    localparam logic [15:0] EXP_COLUMN    = 16'h012C;

    // APB register offsets.
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_ROW        = 8'h04;
    localparam logic [7:0] REG_STATUS     = 8'h08;
    localparam logic [7:0] REG_RESULT     = 8'h0C;
    localparam logic [7:0] REG_TIMES      = 8'h10;

    // Operation codes written to the control register.
    typedef enum logic [1:0] {
        OP_STATUS,
        OP_STATUS_ENH,
        OP_PARAM,
        OP_RESET
    } op_t;

    // Strobe phase timing in ns, rounded up to cycles of clk_in.
    localparam int PHASE_NS     = 32;
    localparam int CLK_NS       = 8;
    localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;

    // NAND pins driven by the host.
    typedef struct packed {
        logic       chip_sel_n;
        logic       cmd_latch;
        logic       addr_latch;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic       write_prot_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nand_pins_t;

endpackage : nand_host_pkg

// ### hdl/nand_host.sv
// Summary of operation
// RULE1 - Check timing-mode bits, mode 0 set
// RULE2 - Read optional cache timing-mode word
// RULE3 - Check program time 0258h
// RULE4 - Check erase time 2710h
// RULE5 - Check page read time 0019h
// RULE6 - Check change-column setup 012Ch
// RULE7 - Bytes 141-253 expected zero
// RULE8 - CRC polynomial x16+x15+x2+1
// RULE9 - Redundant copies follow byte 255
// RULE10 - Sample status during each read strobe
// RULE11 - Status may update without strobe toggle
// RULE12 - Issue 00h before resuming data reads
// RULE13 - Bit 0 is current pass/fail
// RULE14 - Bit 1 is prior page pass/fail
// RULE15 - Bit 5 reports array idle
// RULE16 - Bit 6 reports command ready
// RULE17 - Bit 7 low means protected
// RULE18 - 78h plus three row address cycles
// RULE19 - No 78h during reset or OTP
// RULE20 - Ready/busy pin low while busy
// RULE21 - Multi-plane address limits are software's
// RULE22 - Pages programmed in ascending order
// RULE23 - CRC seed 4F4Eh, MSB first, 0-253
// RULE24 - Status bits 2-4 are ignored
// RULE25 - Ready/busy pin mirrors status bit 6
module nand_host (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output nand_host_pkg::nand_pins_t pins_out,
    input  wire logic [7:0]  io_in,
    input  wire logic        ready_busy_n_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states.
    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_ADDR, S_WAIT, S_READ, S_DONE
    } state_t;
    // All registered state of the host in one record.
    typedef struct packed {
        state_t                    state;
        nand_host_pkg::op_t        op;
        nand_host_pkg::nand_pins_t pins;
        logic [7:0]                cmd;
        logic [23:0]               row;
        logic [1:0]                addr_left;
        logic [2:0]                phase;
        logic [9:0]                index;
        logic [15:0]               crc;
        logic [15:0]               word;
        logic [7:0]                status;
        logic                      busy;
        logic                      wp_n;
        logic [15:0]               tmode;
        logic [15:0]               max_program_time;
        logic [15:0]               max_erase_time;
        logic [15:0]               max_page_read_time;
        logic [15:0]               change_column_setup;
        logic [15:0]               crc_read;
        logic [7:0]                errors;
        logic [31:0]               rdata;
    } host_t;

    host_t r;
    host_t next_r;
    ////////////////////////////////////////////////////////////////////////////
    // One MSB-first CRC byte step over x16+x15+x2+1.
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[15] ^ d[i])
            begin
                v = {v[14:0], 1'b0} ^ nand_host_pkg::CRC_POLY; // [RULE8]
            end
            else
            begin
                v = {v[14:0], 1'b0};
            end
        end
        return v;
    endfunction
    // Phase counter end test, used by every strobe state.
    function automatic logic phase_end(input logic [2:0] p);
        return p == 3'(nand_host_pkg::PHASE_CYC * 2 - 1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: APB decode, pin sequencing and page checking.
    always_comb
    begin
        logic wr;
        logic rd_edge;
        next_r = r;
        wr = psel_in && penable_in && pwrite_in;
        rd_edge = r.phase == 3'(nand_host_pkg::PHASE_CYC - 1);
        // The ready/busy pin is wired-OR; low means some operation is busy.
        next_r.busy = !ready_busy_n_in; // [RULE20] [RULE25]
        // Register writes.
        if (wr && paddr_in == nand_host_pkg::REG_ROW)
        begin
            next_r.row = pwdata_in[23:0];
        end
        if (wr && paddr_in == nand_host_pkg::REG_CTRL)
        begin
            next_r.wp_n = pwdata_in[8];
            if (r.state == S_IDLE && pwdata_in[0])
            begin
                // Programs and multi-plane ops are never issued. [RULE21] [RULE22]
                // Software must not start 78h while reset runs or in OTP mode.
                next_r.op = nand_host_pkg::op_t'(pwdata_in[2:1]); // [RULE19]
                next_r.state = S_CMD;
                next_r.phase = '0;
                next_r.errors = '0;
                next_r.index = '0;
                next_r.crc = nand_host_pkg::CRC_SEED; // [RULE23]
                unique case (nand_host_pkg::op_t'(pwdata_in[2:1]))
                    nand_host_pkg::OP_STATUS:     next_r.cmd = nand_host_pkg::CMD_STATUS;
                    nand_host_pkg::OP_STATUS_ENH: next_r.cmd = nand_host_pkg::CMD_STATUS_ENH;
                    nand_host_pkg::OP_PARAM:      next_r.cmd = nand_host_pkg::CMD_PARAM_PAGE;
                    nand_host_pkg::OP_RESET:      next_r.cmd = nand_host_pkg::CMD_RESET;
                endcase
            end
        end
        next_r.pins.write_prot_n = next_r.wp_n;
        // Pin sequencer.
        unique case (r.state)
            S_IDLE:
            begin
                next_r.pins.chip_sel_n = 1'b1;
                next_r.pins.cmd_latch = 1'b0;
                next_r.pins.addr_latch = 1'b0;
                next_r.pins.io_oe = 1'b0;
                next_r.pins.write_strobe_n = 1'b1;
                next_r.pins.read_strobe_n = 1'b1;
            end
            S_CMD:
            begin
                // A write strobe: low for one half, high for the other.
                next_r.pins.chip_sel_n = 1'b0;
                next_r.pins.cmd_latch = 1'b1;
                next_r.pins.addr_latch = 1'b0;
                next_r.pins.io_oe = 1'b1;
                next_r.pins.io_out = r.cmd;
                next_r.pins.write_strobe_n = !(r.phase < 3'(nand_host_pkg::PHASE_CYC));
                next_r.phase = r.phase + 3'd1;
                if (phase_end(r.phase))
                begin
                    next_r.phase = '0;
                    next_r.addr_left = 2'd3;
                    if (r.op == nand_host_pkg::OP_STATUS_ENH)
                    begin
                        next_r.state = S_ADDR; // [RULE18]
                    end
                    else if (r.op == nand_host_pkg::OP_PARAM)
                    begin
                        next_r.addr_left = 2'd1;
                        next_r.state = S_ADDR;
                    end
                    else if (r.op == nand_host_pkg::OP_RESET)
                    begin
                        next_r.state = S_WAIT;
                    end
                    else
                    begin
                        next_r.state = S_READ;
                    end
                end
            end
            S_ADDR:
            begin
                // Three row bytes for 78h, low first; one zero byte for ECh.
                next_r.pins.cmd_latch = 1'b0;
                next_r.pins.addr_latch = 1'b1;
                next_r.pins.io_out = (r.op == nand_host_pkg::OP_PARAM) ? 8'h00 :
                    r.row[8 * (3 - r.addr_left) +: 8]; // [RULE18]
                next_r.pins.write_strobe_n = !(r.phase < 3'(nand_host_pkg::PHASE_CYC));
                next_r.phase = r.phase + 3'd1;
                if (phase_end(r.phase))
                begin
                    next_r.phase = '0;
                    next_r.addr_left = r.addr_left - 2'd1;
                    if (r.addr_left == 2'd1)
                    begin
                        next_r.state = (r.op == nand_host_pkg::OP_PARAM) ? S_WAIT : S_READ;
                    end
                end
            end
            S_WAIT:
            begin
                // Wait for the busy pin to release; it must go low within 80 ns of the last write strobe rising.
                next_r.pins.addr_latch = 1'b0;
                next_r.pins.cmd_latch = 1'b0;
                next_r.pins.io_oe = 1'b0;
                next_r.phase = (r.phase == 3'd7) ? r.phase : r.phase + 3'd1;
                if (r.phase == 3'd7 && !r.busy)
                begin
                    next_r.phase = '0;
                    next_r.state = (r.op == nand_host_pkg::OP_RESET) ? S_DONE : S_READ;
                end
            end
            S_READ:
            begin
                // Read strobe; data sampled one cycle before it rises.
                next_r.pins.addr_latch = 1'b0;
                next_r.pins.cmd_latch = 1'b0;
                next_r.pins.io_oe = 1'b0;
                next_r.pins.read_strobe_n = !(r.phase < 3'(nand_host_pkg::PHASE_CYC));
                next_r.phase = r.phase + 3'd1;
                if (rd_edge)
                begin
                    if (r.op != nand_host_pkg::OP_PARAM)
                    begin
                        // Status byte; bits 2-4 carry nothing and are masked.
                        next_r.status = io_in & ~nand_host_pkg::ST_DONT_CARE_MASK; // [RULE10] [RULE24]
                    end
                    else
                    begin
                        if (r.index <= nand_host_pkg::PP_CRC_END)
                        begin
                            next_r.crc = crc_step(r.crc, io_in); // [RULE23]
                        end
                        next_r.word = {io_in, r.word[15:8]};
                        // Reserved and vendor bytes must be zero.
                        if (r.index > nand_host_pkg::PP_COLUMN_LO + 10'd1 &&
                            r.index <= nand_host_pkg::PP_CRC_END && io_in != 8'h00)
                        begin
                            next_r.errors[6] = 1'b1; // [RULE7]
                        end
                    end
                end
                if (phase_end(r.phase))
                begin
                    next_r.phase = '0;
                    if (r.op != nand_host_pkg::OP_PARAM)
                    begin
                        next_r.state = S_DONE;
                    end
                    else
                    begin
                        next_r.index = r.index + 10'd1;
                        unique case (r.index)
                            nand_host_pkg::PP_TMODE_LO + 10'd1:
                            begin
                                next_r.tmode = r.word;
                                next_r.errors[0] = !r.word[0] || |r.word[15:6]; // [RULE1]
                            end
                            nand_host_pkg::PP_TMODE_LO + 10'd3:
                            begin
                                next_r.errors[1] = |r.word[15:6]; // [RULE2]
                            end
                            nand_host_pkg::PP_PROG_LO + 10'd1:
                            begin
                                next_r.max_program_time = r.word;
                                next_r.errors[2] = r.word != nand_host_pkg::EXP_PROG; // [RULE3]
                            end
                            nand_host_pkg::PP_ERASE_LO + 10'd1:
                            begin
                                next_r.max_erase_time = r.word;
                                next_r.errors[3] = r.word != nand_host_pkg::EXP_ERASE; // [RULE4]
                            end
                            nand_host_pkg::PP_READ_LO + 10'd1:
                            begin
                                next_r.max_page_read_time = r.word;
                                next_r.errors[4] = r.word != nand_host_pkg::EXP_READ; // [RULE5]
                            end
                            nand_host_pkg::PP_COLUMN_LO + 10'd1:
                            begin
                                next_r.change_column_setup = r.word;
                                next_r.errors[5] = r.word != nand_host_pkg::EXP_COLUMN; // [RULE6]
                            end
                            nand_host_pkg::PP_CRC_HI:
                            begin
                                // Little-endian CRC; copies at 256+ are not read.
                                next_r.crc_read = r.word;
                                next_r.errors[7] = r.word != r.crc; // [RULE8] [RULE9]
                                next_r.state = S_DONE;
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                end
            end
            S_DONE:
            begin
                // Status mode persists; each op opens with its own command. [RULE12]
                next_r.pins.read_strobe_n = 1'b1;
                next_r.pins.chip_sel_n = 1'b1;
                next_r.state = S_IDLE; // [RULE11]
            end
            default:
            begin
                next_r.state = S_IDLE;
            end
        endcase
        // Read data mux, registered for the access phase.
        unique case (paddr_in)
            nand_host_pkg::REG_CTRL:   next_r.rdata = {23'h0, r.wp_n, 5'h0, r.op, 1'b0};
            nand_host_pkg::REG_ROW:    next_r.rdata = {8'h00, r.row};
            nand_host_pkg::REG_STATUS: next_r.rdata = {14'h0, r.busy, r.state != S_IDLE,
                                                       r.errors, r.status}; // [RULE13] [RULE14] [RULE15] [RULE16] [RULE17]
            nand_host_pkg::REG_RESULT: next_r.rdata = {r.crc_read, r.tmode};
            nand_host_pkg::REG_TIMES:  next_r.rdata = {r.max_erase_time, r.max_program_time};
            default:                   next_r.rdata = {r.change_column_setup,
                                                       r.max_page_read_time};
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r <= '0;
            r.state <= S_IDLE;
            r.pins.chip_sel_n <= 1'b1;
            r.pins.write_strobe_n <= 1'b1;
            r.pins.read_strobe_n <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end
    // Every access completes in its first access cycle.
    assign pready_out  = 1'b1;
    assign pslverr_out = 1'b0;
    assign prdata_out  = r.rdata;
    assign pins_out    = r.pins;
endmodule // nand_host

// ### dv/nand_host_assertions.sv
module nand_host_assertions (
    input wire logic                      clk_in,
    input wire logic                      rst_in,
    input wire logic                      psel_in,
    input wire logic                      penable_in,
    input wire logic                      pwrite_in,
    input wire logic [7:0]                paddr_in,
    input wire logic [31:0]               prdata_out,
    input wire logic                      pready_out,
    input wire logic                      pslverr_out,
    input wire nand_host_pkg::nand_pins_t pins_out,
    input wire logic                      ready_busy_n_in
);
    // One clock domain, so clocking and reset are stated once.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    strobe_overlap_a: assert property (!(!pins_out.write_strobe_n && !pins_out.read_strobe_n))
        else $error("both strobes low");
    write_pulse_a: assert property ($fell(pins_out.write_strobe_n) |->
        (!pins_out.write_strobe_n) [*4] ##1 pins_out.write_strobe_n)
        else $error("write strobe pulse not four cycles");
    read_pulse_a: assert property ($fell(pins_out.read_strobe_n) |->
        (!pins_out.read_strobe_n) [*4] ##1 pins_out.read_strobe_n)
        else $error("read strobe pulse not four cycles");
    select_strobe_a: assert property (!pins_out.write_strobe_n || !pins_out.read_strobe_n
        |-> !pins_out.chip_sel_n)
        else $error("strobe without chip select");
    read_release_a: assert property (!pins_out.read_strobe_n |-> !pins_out.io_oe)
        else $error("host drives data during a read");
    latch_overlap_a: assert property (!(pins_out.cmd_latch && pins_out.addr_latch))
        else $error("command and address latch together");
    busy_no_read_a: assert property (!ready_busy_n_in |-> pins_out.read_strobe_n)
        else $error("read strobe while device busy");
    status_mask_a: assert property (psel_in && penable_in && !pwrite_in
        && paddr_in == nand_host_pkg::REG_STATUS |-> prdata_out[4:2] == 3'b000)
        else $error("meaningless status bits not zero");
    bus_answer_a: assert property (psel_in && penable_in |-> pready_out && !pslverr_out)
        else $error("bus answer late or in error");
    // The main scenarios: a command, a busy period and a data read.
    cover property ($fell(pins_out.cmd_latch));
    cover property ($fell(ready_busy_n_in));
    cover property ($fell(pins_out.read_strobe_n));
endmodule // nand_host_assertions

bind nand_host nand_host_assertions i_nand_host_assertions (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pins_out(pins_out), .ready_busy_n_in(ready_busy_n_in));

// ### dv/nand_dev_model.sv
module nand_dev_model #(
    parameter int BUSY_NS = 2000 // Length of a reset or page load busy period.
) (
    input  wire nand_host_pkg::nand_pins_t pins_in,
    input  wire logic [1:0]                fail_in,
    input  wire logic                      corrupt_in,
    output logic      [7:0]                io_out,
    output logic                           rb_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  page [256]; // Parameter page image.
    logic [7:0]  cmd;        // Last command latched.
    logic [23:0] row;        // Row bytes of the latest address cycles.
    logic [7:0]  idx;        // Read pointer; it wraps, so copies repeat.
    logic [15:0] crc;        // Integrity check word.
    logic        busy;       // An array or reset operation runs.
    logic [7:0]  stat;
    logic [7:0]  data;
    ////////////////////////////////////////
    // The page is built once; reserved and vendor bytes stay zero.
    initial
    begin
        busy = 1'b0;
        cmd = 8'h00;
        idx = 8'h00;
        row = 24'h00_0000;
        for (int i = 0; i < 256; i++)
            page[i] = 8'h00;
        page[129] = 8'h1F; // Mode 0 is always set.
        page[131] = 8'h1F;
        page[133] = 8'h58;
        page[134] = 8'h02;
        page[135] = 8'h10;
        page[136] = 8'h27;
        page[137] = 8'h19;
        page[139] = 8'h2C;
        page[140] = 8'h01;
        crc = 16'h4F4E;
        for (int i = 0; i < 254; i++)
            for (int b = 7; b >= 0; b--)
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ page[i][b]) ? 16'h8005 : 16'h0000);
        page[254] = crc[7:0];
        page[255] = crc[15:8];
    end
    ////////////////////////////////////////
    // Commands and addresses land on the rising write strobe.
    always @(posedge pins_in.write_strobe_n)
    begin
        if (!pins_in.chip_sel_n && !busy)
        begin
            if (pins_in.cmd_latch)
            begin
                cmd = pins_in.io_out; // Status mode lasts until a new command.
                idx = 8'h00;
            end
            if (pins_in.addr_latch)
                row = {pins_in.io_out, row[23:8]}; // Row bytes arrive low first.
            if ((pins_in.cmd_latch && cmd == nand_host_pkg::CMD_RESET)
                || (pins_in.addr_latch && cmd == nand_host_pkg::CMD_PARAM_PAGE))
            begin
                busy = 1'b1;
                #(BUSY_NS);
                busy = 1'b0;
            end
        end
    end
    // Each completed read cycle of the page advances the pointer.
    always @(posedge pins_in.read_strobe_n)
        if (!pins_in.chip_sel_n && cmd == nand_host_pkg::CMD_PARAM_PAGE)
            idx = idx + 8'h01;
    // Status follows progress live; a released bus shows the inverse, not a stale value.
    always_comb
    begin
        stat = {pins_in.write_prot_n, !busy, !busy, 3'b000, fail_in};
        data = (cmd == nand_host_pkg::CMD_PARAM_PAGE)
            ? page[idx] ^ {7'h00, corrupt_in && idx == 8'hFE} : stat;
        io_out = (!pins_in.chip_sel_n && !pins_in.read_strobe_n) ? data : ~data;
    end
    assign rb_n_out = !busy; // Pulled up when released.
endmodule // nand_dev_model

// ### dv/tb_nand_host.sv
module tb_nand_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [7:0]  io_in;
    logic        ready_busy_n_in;
    logic [1:0]  fail = 2'b00;   // Pass or fail flags the model reports.
    logic        corrupt = 1'b0; // Spoils the check word on the wire.
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          busy_seen = 0;  // Cycles with the busy pin low.
    nand_host_pkg::nand_pins_t pins_out;
    always #4 clk_in = ~clk_in;
    nand_host i_nand_host (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .pins_out(pins_out), .io_in(io_in),
        .ready_busy_n_in(ready_busy_n_in));
    nand_dev_model i_nand_dev_model (.pins_in(pins_out), .fail_in(fail),
        .corrupt_in(corrupt), .io_out(io_in), .rb_n_out(ready_busy_n_in));
    ////////////////////////////////////////
    // A hang is cut short well beyond the longest expected run.
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (!ready_busy_n_in)
            busy_seen <= busy_seen + 1;
        if (cycles == 40000)
        begin
            mismatches = mismatches + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One bus transfer; read data is taken at the edge that sees pready.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
            @(posedge clk_in);
        while (pready_out !== 1'b1);
        q = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    // Starts an operation and polls until it no longer runs.
    task automatic run_op(input nand_host_pkg::op_t op, input logic wp, output logic [31:0] st);
        logic [31:0] q;
        apb(1'b1, nand_host_pkg::REG_CTRL, {23'h00_0000, wp, 5'h00, 2'(op), 1'b1}, q);
        // Only the bench timeout ends a hang, so a stuck op is counted.
        do
            apb(1'b0, nand_host_pkg::REG_STATUS, 32'h0000_0000, st);
        while (st[16] !== 1'b0);
    endtask
    ////////////////////////////////////////
    task automatic t_status(input logic wp, input logic [1:0] f, input logic [7:0] exp);
        logic [31:0] st;
        fail = f;
        run_op(nand_host_pkg::OP_STATUS, wp, st);
        chk(st & 32'h0000_00FF, {24'h00_0000, exp}, "status byte");
    endtask
    task automatic t_enh();
        logic [31:0] st;
        logic [31:0] q;
        fail = 2'b00;
        apb(1'b1, nand_host_pkg::REG_ROW, 32'h0003_0201, q);
        run_op(nand_host_pkg::OP_STATUS_ENH, 1'b1, st);
        chk({8'h00, i_nand_dev_model.row}, 32'h0003_0201, "row address");
        chk(st & 32'h0000_00FF, 32'h0000_00E0, "plane status");
    endtask
    // A spoiled check word must raise the mismatch flag alone.
    task automatic t_param(input logic c, input logic [7:0] err);
        logic [31:0] st;
        logic [31:0] q;
        corrupt = c;
        run_op(nand_host_pkg::OP_PARAM, 1'b1, st);
        chk(st & 32'h0000_FF00, {16'h0000, err, 8'h00}, "page errors");
        apb(1'b0, nand_host_pkg::REG_TIMES, 32'h0000_0000, q);
        chk(q, 32'h2710_0258, "erase and program time");
        apb(1'b0, 8'h14, 32'h0000_0000, q);
        chk(q, 32'h012C_0019, "read and column time");
        apb(1'b0, nand_host_pkg::REG_RESULT, 32'h0000_0000, q);
        chk(q, {i_nand_dev_model.crc ^ {15'h0000, c}, 16'h001F}, "crc and modes");
        corrupt = 1'b0;
    endtask
    task automatic t_reset();
        logic [31:0] st;
        busy_seen = 0;
        run_op(nand_host_pkg::OP_RESET, 1'b1, st);
        chk(32'(busy_seen > 200), 32'h0000_0001, "busy pin low");
        chk(st & 32'h0003_0000, 32'h0000_0000, "idle after reset");
    endtask
    task automatic t_unmapped();
        logic [31:0] q;
        apb(1'b0, 8'h40, 32'h0000_0000, q);
        chk(q, 32'h012C_0019, "unmapped read");
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_status(1'b1, 2'b00, 8'hE0);
        t_status(1'b0, 2'b11, 8'h63);
        t_enh();
        t_param(1'b0, 8'h00);
        t_param(1'b1, 8'h80);
        t_reset();
        t_unmapped();
        conclude();
    end
endmodule // tb_nand_host
